//--- rtl/dio_override.v
`timescale 1ns/100ps
`include "dio_regs.vh"
module dio_override #(
   parameter SAVE_CYC = `DIO_SAVE_TIME_MS * `DIO_CLK_KHZ,
   parameter FLASH_CYC = 12500000
)(
   input wire MCLK_I,
   input wire SRST_I,
   input wire [5:0] AVS_ADDRESS_I,
   input wire AVS_READ_I,
   input wire AVS_WRITE_I,
   input wire [31:0] AVS_WRITEDATA_I,
   input wire [3:0] AVS_BYTEENABLE_I,
   output reg [31:0] AVS_READDATA_O,
   output reg AVS_WAITREQUEST_O,
   input wire BIAS_UP_I,
   input wire BIAS_DOWN_I,
   input wire KEB_NC_I,
   input wire KEB_NO_I,
   input wire PI2_DIS_NO_I,
   input wire PI2_DIS_NC_I,
   input wire PI2_INV_I,
   input wire PI2_IRST_I,
   input wire PI2_IHOLD_I,
   input wire PI2_PSEL_I,
   input wire OVR_FWD_I,
   input wire OVR_REV_I,
   input wire DRV_EN_I,
   input wire RUN_I,
   input wire ESTOP_I,
   input wire SLEEP_I,
   output reg [15:0] FREQ_REF_O,
   output reg KEB_TRIG_O,
   output reg PI2_ENABLE_O,
   output reg PI2_INVERT_O,
   output reg PI2_INT_CLR_O,
   output reg PI2_INT_HOLD_O,
   output reg PI1_ALT_GAIN_O,
   output reg OVR_ACTIVE_O,
   output reg OVR_DIR_REV_O,
   output reg EXT_FAULT_O,
   output reg FAULT_CLR_O,
   output reg SS_UNLIMITED_O,
   output reg SERIAL_ERR_OFF_O,
   output reg ALARM_FLASH_O,
   output reg RUN_O,
   output reg SLEEP_O
);
// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
localparam NIN = 15;
wire [NIN-1:0] pin_w = {SLEEP_I, ESTOP_I, RUN_I, DRV_EN_I, OVR_REV_I,
   OVR_FWD_I, PI2_PSEL_I, PI2_IHOLD_I, PI2_IRST_I, PI2_INV_I,
   PI2_DIS_NC_I, PI2_DIS_NO_I, KEB_NO_I, KEB_NC_I,
   BIAS_UP_I ^ 1'b0};
reg [NIN-1:0] s1_q, s2_q, s3_q, in_q;
genvar g;
generate
   for (g = 0; g < NIN; g = g + 1)
   begin : g_sync
      always @(posedge MCLK_I)
      begin
         if (SRST_I)
         begin
            s1_q[g] <= 1'b0;
            s2_q[g] <= 1'b0;
            s3_q[g] <= 1'b0;
            in_q[g] <= 1'b0;
         end
         else
         begin
            s1_q[g] <= pin_w[g];
            s2_q[g] <= s1_q[g];
            s3_q[g] <= s2_q[g];
            // Change counts only when stages agree
            if (s2_q[g] == s3_q[g])
               in_q[g] <= s3_q[g];
         end
      end
   end
endgenerate
reg dn_s1_q, dn_s2_q, dn_s3_q, dn_q;
always @(posedge MCLK_I)
begin
   if (SRST_I)
   begin
      dn_s1_q <= 1'b0;
      dn_s2_q <= 1'b0;
      dn_s3_q <= 1'b0;
      dn_q <= 1'b0;
   end
   else
   begin
      dn_s1_q <= BIAS_DOWN_I;
      dn_s2_q <= dn_s1_q;
      dn_s3_q <= dn_s2_q;
      if (dn_s2_q == dn_s3_q)
         dn_q <= dn_s3_q;
   end
end
wire up_w = in_q[0];
wire dn_w = dn_q;
wire keb_nc_w = in_q[1];
wire keb_no_w = in_q[2];
wire dis_no_w = in_q[3];
wire dis_nc_w = in_q[4];
wire inv_w = in_q[5];
wire irst_w = in_q[6];
wire ihold_w = in_q[7];
wire psel_w = in_q[8];
wire ofwd_w = in_q[9];
wire orev_w = in_q[10];
wire en_w = in_q[11];
wire run_w = in_q[12];
wire estop_w = in_q[13];
wire sleep_w = in_q[14];
// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] ctrl_q;
reg [15:0] bstep_q, ref_q, ovspd_q, chgt_q, saved_q;
reg signed [16:0] bias_q;
reg [15:0] fout_q;
wire hold_w = ctrl_q[`DIO_C_HOLD];
wire mstep_w = ctrl_q[`DIO_C_MSTEP];
wire wr_w = AVS_WRITE_I & ~AVS_WAITREQUEST_O;
// Read data loads in the wait cycle so it stands at acceptance
wire rd_w = AVS_READ_I & AVS_WAITREQUEST_O;
// Merge write data by byte lanes
function [15:0] merge16;
   input [15:0] old;
   input [31:0] wd;
   input [3:0] be;
   begin
      merge16[7:0] = be[0] ? wd[7:0] : old[7:0];
      merge16[15:8] = be[1] ? wd[15:8] : old[15:8];
   end
endfunction
// ----------------------------------------
// Override sequencing
// ----------------------------------------
wire ov_req_w = ctrl_q[`DIO_C_OVEN] & (ofwd_w ^ orev_w);
wire both_w = ctrl_q[`DIO_C_OVEN] & ofwd_w & orev_w;
wire ov_ok_w = ov_req_w & ~en_w;
reg ov_q;
reg run_armed_q;
reg [23:0] fl_cnt_q;
// ----------------------------------------
// Bias logic
// ----------------------------------------
reg [15:0] ref_prev_q;
reg signed [16:0] bias_prev_q;
reg [31:0] st_cnt_q;
reg chg_hold_q;
reg [15:0] chg_cnt_q;
wire ref_chg_w = ref_q != ref_prev_q;
wire bias_chg_w = bias_q != bias_prev_q;
wire up_only_w = up_w & ~dn_w;
wire dn_only_w = dn_w & ~up_w;
wire ramp_w = ctrl_q[`DIO_C_ACCEL];
wire agree_w = ctrl_q[`DIO_C_AGREE];
always @(posedge MCLK_I)
begin
   if (SRST_I)
   begin
      ctrl_q <= `DIO_CTRL_RST;
      bstep_q <= 16'h0000;
      ref_q <= 16'h0000;
      ovspd_q <= 16'h0000;
      chgt_q <= 16'h0000;
      saved_q <= 16'h0000;
      bias_q <= 17'h00000;
      bias_prev_q <= 17'h00000;
      ref_prev_q <= 16'h0000;
      st_cnt_q <= 32'h00000000;
      chg_cnt_q <= 16'h0000;
      chg_hold_q <= 1'b0;
      ov_q <= 1'b0;
      run_armed_q <= 1'b0;
      fl_cnt_q <= 24'h000000;
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h00000000;
      FREQ_REF_O <= 16'h0000;
      KEB_TRIG_O <= 1'b0;
      PI2_ENABLE_O <= 1'b0;
      PI2_INVERT_O <= 1'b0;
      PI2_INT_CLR_O <= 1'b0;
      PI2_INT_HOLD_O <= 1'b0;
      PI1_ALT_GAIN_O <= 1'b0;
      OVR_ACTIVE_O <= 1'b0;
      OVR_DIR_REV_O <= 1'b0;
      EXT_FAULT_O <= 1'b0;
      FAULT_CLR_O <= 1'b0;
      SS_UNLIMITED_O <= 1'b0;
      SERIAL_ERR_OFF_O <= 1'b0;
      ALARM_FLASH_O <= 1'b0;
      RUN_O <= 1'b0;
      SLEEP_O <= 1'b0;
   end
   else
   begin
      // Bus: one wait cycle, then answer
      AVS_WAITREQUEST_O <= ~((AVS_READ_I | AVS_WRITE_I) &
         AVS_WAITREQUEST_O);
      if (wr_w)
      begin
         if (AVS_ADDRESS_I == `DIO_OFS_CTRL)
         begin
            if (AVS_BYTEENABLE_I[0])
               ctrl_q <= AVS_WRITEDATA_I[7:0];
         end
         else if (AVS_ADDRESS_I == `DIO_OFS_BSTEP)
            bstep_q <= merge16(bstep_q, AVS_WRITEDATA_I,
               AVS_BYTEENABLE_I);
         else if (AVS_ADDRESS_I == `DIO_OFS_REF)
            ref_q <= merge16(ref_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
         else if (AVS_ADDRESS_I == `DIO_OFS_OVSPD)
            ovspd_q <= merge16(ovspd_q, AVS_WRITEDATA_I,
               AVS_BYTEENABLE_I);
         else if (AVS_ADDRESS_I == `DIO_OFS_CHGT)
            chgt_q <= merge16(chgt_q, AVS_WRITEDATA_I,
               AVS_BYTEENABLE_I);
      end
      if (rd_w)
      begin
         // Unmapped reads return zero
         if (AVS_ADDRESS_I == `DIO_OFS_CTRL)
            AVS_READDATA_O <= {24'h000000, ctrl_q};
         else if (AVS_ADDRESS_I == `DIO_OFS_BSTEP)
            AVS_READDATA_O <= {16'h0000, bstep_q};
         else if (AVS_ADDRESS_I == `DIO_OFS_REF)
            AVS_READDATA_O <= {16'h0000, ref_q};
         else if (AVS_ADDRESS_I == `DIO_OFS_OVSPD)
            AVS_READDATA_O <= {16'h0000, ovspd_q};
         else if (AVS_ADDRESS_I == `DIO_OFS_STAT)
            AVS_READDATA_O <= {24'h000000, chg_hold_q, RUN_O,
               EXT_FAULT_O, OVR_DIR_REV_O, ov_q, KEB_TRIG_O,
               PI2_ENABLE_O, ALARM_FLASH_O};
         else if (AVS_ADDRESS_I == `DIO_OFS_BIAS)
            AVS_READDATA_O <= {{15{bias_q[16]}}, bias_q};
         else if (AVS_ADDRESS_I == `DIO_OFS_SAVED)
            AVS_READDATA_O <= {16'h0000, saved_q};
         else if (AVS_ADDRESS_I == `DIO_OFS_FREF)
            AVS_READDATA_O <= {16'h0000, FREQ_REF_O};
         else if (AVS_ADDRESS_I == `DIO_OFS_CHGT)
            AVS_READDATA_O <= {16'h0000, chgt_q};
         else
            AVS_READDATA_O <= 32'h00000000;
      end
      // Bias adjust
      ref_prev_q <= ref_q;
      bias_prev_q <= bias_q;
      // Reference moving in a ramp freezes bias until agree
      if (~mstep_w & ramp_w & ref_chg_w)
         chg_cnt_q <= chg_cnt_q + 16'h0001;
      else if (~ramp_w)
         chg_cnt_q <= 16'h0000;
      if (~mstep_w & ramp_w & (chg_cnt_q > chgt_q))
         chg_hold_q <= 1'b1;
      else if (agree_w)
         chg_hold_q <= 1'b0;
      if (mstep_w & hold_w & ref_chg_w)
         bias_q <= 17'h00000;
      else if (chg_hold_q)
         bias_q <= bias_q;
      else if (bstep_q == 16'h0000)
      begin
         if (up_only_w)
            bias_q <= bias_q + 17'h00001;
         else if (dn_only_w)
            bias_q <= bias_q - 17'h00001;
         else if (~hold_w)
            bias_q <= 17'h00000;
         // Else hold keeps bias
      end
      else
      begin
         if (up_only_w)
            bias_q <= {1'b0, bstep_q};
         else if (dn_only_w)
            bias_q <= 17'h00000 - {1'b0, bstep_q};
         else if (~hold_w)
            bias_q <= 17'h00000;
      end
      // Steady timer
      if (ref_chg_w | bias_chg_w | ~hold_w | bias_q == 17'h00000)
         st_cnt_q <= 32'h00000000;
      else if (st_cnt_q >= SAVE_CYC - 1)
      begin
         st_cnt_q <= 32'h00000000;
         if (mstep_w)
         begin
            ref_q <= ref_q + bias_q[15:0];
            ref_prev_q <= ref_q + bias_q[15:0];
            bias_q <= 17'h00000;
         end
         else
            saved_q <= bias_q[15:0];
      end
      // Counts only while bias and reference stand
      else
         st_cnt_q <= st_cnt_q + 32'h00000001;
      // Override state
      FAULT_CLR_O <= 1'b0;
      if (ov_ok_w & ~ov_q)
      begin
         ov_q <= 1'b1;
         FAULT_CLR_O <= 1'b1;
      end
      else if (~ov_req_w)
         ov_q <= 1'b0;
      EXT_FAULT_O <= both_w;
      // Drive enable gating of normal run
      if (~run_w)
         run_armed_q <= 1'b1;
      else if (~en_w)
         run_armed_q <= 1'b0;
      RUN_O <= ov_q | (run_w & en_w & run_armed_q & ~estop_w);
      SLEEP_O <= sleep_w & ~ov_q;
      OVR_ACTIVE_O <= ov_q;
      OVR_DIR_REV_O <= ov_q & orev_w;
      SS_UNLIMITED_O <= ov_q;
      SERIAL_ERR_OFF_O <= ov_q;
      if (~ov_q | fl_cnt_q >= FLASH_CYC - 1)
         fl_cnt_q <= 24'h000000;
      else
         fl_cnt_q <= fl_cnt_q + 24'h000001;
      if (~ov_q)
         ALARM_FLASH_O <= 1'b0;
      else if (fl_cnt_q == 24'h000000)
         ALARM_FLASH_O <= ~ALARM_FLASH_O;
      if (ov_q)
         FREQ_REF_O <= ctrl_q[`DIO_C_OVREF] ? ref_q : ovspd_q;
      else
         FREQ_REF_O <= ref_q + bias_q[15:0];
      // Ride-through and secondary PI
      KEB_TRIG_O <= ~keb_nc_w | keb_no_w;
      PI2_ENABLE_O <= ctrl_q[`DIO_C_PI2EN] & ~dis_no_w & dis_nc_w;
      PI2_INVERT_O <= inv_w;
      PI2_INT_CLR_O <= irst_w;
      PI2_INT_HOLD_O <= ihold_w;
      PI1_ALT_GAIN_O <= psel_w & ~ctrl_q[`DIO_C_PI2EN];
   end
end
endmodule // dio_override

//--- rtl/dio_regs.vh
`ifndef DIO_REGS_VH
`define DIO_REGS_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DIO_OFS_CTRL 6'h00
`define DIO_OFS_BSTEP 6'h04
`define DIO_OFS_REF 6'h08
`define DIO_OFS_OVSPD 6'h0C
`define DIO_OFS_STAT 6'h10
`define DIO_OFS_BIAS 6'h14
`define DIO_OFS_SAVED 6'h18
`define DIO_OFS_FREF 6'h1C
`define DIO_OFS_CHGT 6'h20
// ----------------------------------------
// CTRL fields
// ----------------------------------------
`define DIO_C_HOLD 0
`define DIO_C_MSTEP 1
`define DIO_C_OVEN 2
`define DIO_C_OVREF 3
`define DIO_C_PI2EN 4
`define DIO_C_ACCEL 5
`define DIO_C_AGREE 6
`define DIO_C_FCLR 7
`define DIO_CTRL_RST 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define DIO_SAVE_TIME_MS 5000
`define DIO_CLK_KHZ 25000
`endif

//--- tb/dio_contacts.sv
`timescale 1ns/100ps
module dio_contacts (
   input wire logic MCLK_I,
   input wire logic [15:0] cmd_i,
   output logic [15:0] pins_o
);
   // ----------------------------------------
   // Contacts follow the command one edge late
   // ----------------------------------------
   initial pins_o = 16'h0000;
   always @(posedge MCLK_I)
   begin
      // Enable opened on the same edge as any override contact, else override never engages
      pins_o <= (cmd_i[10] || cmd_i[11]) ? (cmd_i & 16'hEFFF) : cmd_i;
   end
endmodule // dio_contacts

//--- tb/dio_override_props.sv
`timescale 1ns/100ps
module dio_override_props (
   input logic MCLK_I,
   input logic SRST_I,
   input logic OVR_FWD_I,
   input logic OVR_REV_I,
   input logic DRV_EN_I,
   input logic KEB_NC_I,
   input logic KEB_NO_I,
   input logic PI2_INV_I,
   input logic OVR_ACTIVE_O,
   input logic FAULT_CLR_O,
   input logic SS_UNLIMITED_O,
   input logic SERIAL_ERR_OFF_O,
   input logic ALARM_FLASH_O,
   input logic KEB_TRIG_O,
   input logic PI2_INVERT_O,
   input logic PI2_DIS_NO_I,
   input logic PI2_DIS_NC_I,
   input logic PI2_ENABLE_O,
   input logic EXT_FAULT_O
);
   // ----------------------------------------
   // Override and pin function checks
   // ----------------------------------------
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (SRST_I);
   // Eight cycles covers the three-stage sync plus output register
   sequence s_en_closed;
      DRV_EN_I [*8];
   endsequence
   sequence s_no_request;
      (!OVR_FWD_I && !OVR_REV_I) [*8];
   endsequence
   sequence s_entry;
      $rose(OVR_ACTIVE_O);
   endsequence
   ovr_needs_open_a:
      assert property (s_en_closed |=> !OVR_ACTIVE_O)
      else $error("override active with enable closed");
   ovr_release_a:
      assert property (s_no_request |=> !OVR_ACTIVE_O)
      else $error("override active without request");
   fault_clear_a:
      assert property (s_entry |-> $past(FAULT_CLR_O))
      else $error("no fault clear at override entry");
   search_retry_a:
      assert property (OVR_ACTIVE_O && $past(OVR_ACTIVE_O) |-> SS_UNLIMITED_O)
      else $error("speed search limited in override");
   serial_off_a:
      assert property (OVR_ACTIVE_O && $past(OVR_ACTIVE_O) |->
         SERIAL_ERR_OFF_O)
      else $error("serial error detection on in override");
   flash_quiet_a:
      assert property (!OVR_ACTIVE_O && !$past(OVR_ACTIVE_O) |->
         !ALARM_FLASH_O)
      else $error("alarm flash outside override");
   flash_blink_a:
      assert property (OVR_ACTIVE_O && !ALARM_FLASH_O |->
         ##[1:24] (ALARM_FLASH_O || !OVR_ACTIVE_O))
      else $error("alarm never flashes in override");
   keb_trig_a:
      assert property ((KEB_NO_I || !KEB_NC_I) [*6] |=> KEB_TRIG_O)
      else $error("ride-through trigger missing");
   pi2_invert_a:
      assert property (PI2_INV_I [*6] |=> PI2_INVERT_O)
      else $error("secondary input not inverted");
   pi2_disable_a:
      assert property ((PI2_DIS_NO_I || !PI2_DIS_NC_I) [*6] |=>
         !PI2_ENABLE_O)
      else $error("secondary controller enabled while disabled");
   fault_quiet_a:
      assert property ((!(OVR_FWD_I && OVR_REV_I)) [*8] |=> !EXT_FAULT_O)
      else $error("external fault without both override inputs");
endmodule // dio_override_props

bind dio_override dio_override_props dio_override_props_i (
   .MCLK_I(MCLK_I), .SRST_I(SRST_I), .OVR_FWD_I(OVR_FWD_I),
   .OVR_REV_I(OVR_REV_I), .DRV_EN_I(DRV_EN_I), .KEB_NC_I(KEB_NC_I),
   .KEB_NO_I(KEB_NO_I), .PI2_INV_I(PI2_INV_I), .OVR_ACTIVE_O(OVR_ACTIVE_O),
   .FAULT_CLR_O(FAULT_CLR_O), .SS_UNLIMITED_O(SS_UNLIMITED_O),
   .SERIAL_ERR_OFF_O(SERIAL_ERR_OFF_O), .ALARM_FLASH_O(ALARM_FLASH_O),
   .KEB_TRIG_O(KEB_TRIG_O), .PI2_INVERT_O(PI2_INVERT_O),
   .PI2_DIS_NO_I(PI2_DIS_NO_I), .PI2_DIS_NC_I(PI2_DIS_NC_I),
   .PI2_ENABLE_O(PI2_ENABLE_O), .EXT_FAULT_O(EXT_FAULT_O));

//--- tb/drive_input_override_logic_tb_top.sv
`timescale 1ns/100ps
`include "dio_regs.vh"
module drive_input_override_logic_tb_top;
   // ----------------------------------------
   // Stimulus, model and checks
   // ----------------------------------------
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [31:0] wdat = 32'h0;
   logic [15:0] cmd = 16'h0004;
   logic [31:0] r;
   wire [31:0] rdat;
   wire wreq;
   wire [15:0] p;
   wire [15:0] fref;
   wire [14:0] o;
   int fail_count = 0;
   int compares = 0;
   int ref_m;
   int b;
   int b2;
   int pt[6] = '{6, 7, 8, 9, 3, 2};
   logic [4:0] ex[6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h01};
   initial
   begin
      forever #20 clk = ~clk;
   end
   dio_contacts dio_contacts_i (.MCLK_I(clk), .cmd_i(cmd), .pins_o(p));
   dio_override #(.SAVE_CYC(200), .FLASH_CYC(10)) dio_override_i (
      .MCLK_I(clk), .SRST_I(srst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'hF),
      .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .BIAS_UP_I(p[0]),
      .BIAS_DOWN_I(p[1]), .KEB_NC_I(p[2]), .KEB_NO_I(p[3]),
      .PI2_DIS_NO_I(p[4]), .PI2_DIS_NC_I(p[5]), .PI2_INV_I(p[6]),
      .PI2_IRST_I(p[7]), .PI2_IHOLD_I(p[8]), .PI2_PSEL_I(p[9]),
      .OVR_FWD_I(p[10]), .OVR_REV_I(p[11]), .DRV_EN_I(p[12]), .RUN_I(p[13]),
      .ESTOP_I(p[14]), .SLEEP_I(p[15]), .FREQ_REF_O(fref),
      .KEB_TRIG_O(o[0]), .PI1_ALT_GAIN_O(o[1]), .PI2_INT_HOLD_O(o[2]),
      .PI2_INT_CLR_O(o[3]), .PI2_INVERT_O(o[4]), .PI2_ENABLE_O(o[5]),
      .OVR_ACTIVE_O(o[6]), .OVR_DIR_REV_O(o[7]), .EXT_FAULT_O(o[8]),
      .FAULT_CLR_O(o[9]), .SS_UNLIMITED_O(o[10]), .SERIAL_ERR_OFF_O(o[11]),
      .ALARM_FLASH_O(o[12]), .RUN_O(o[13]), .SLEEP_O(o[14]));
   // Request held until waitrequest seen low at an edge
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      begin
         @(posedge clk);
         adr <= a;
         wdat <= d;
         wr <= w;
         rd <= !w;
         do
         begin
            @(posedge clk);
         end
         while (wreq !== 1'b0);
         r = rdat;
         wr <= 1'b0;
         rd <= 1'b0;
      end
   endtask
   task chk16(input logic [15:0] g, input logic [15:0] e);
      begin
         compares++;
         if (g !== e)
         begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask
   task chk1(input logic g, input logic e);
      chk16({15'h0, g}, {15'h0, e});
   endtask
   // Twelve cycles outlasts the input sync latency
   task pins(input logic [15:0] c);
      begin
         @(posedge clk);
         cmd <= c;
         repeat (12) @(posedge clk);
      end
   endtask
   task results;
      begin
         $display("compares %0d mismatches %0d", compares, fail_count);
         if (fail_count == 0 && compares > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      results;
   end
   initial
   begin
      void'($urandom(6));
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      bus(0, 6'h24, 0);
      chk16(r[15:0], 16'h0000);
      ref_m = ($urandom % 2048) + 1024;
      bus(1, `DIO_OFS_REF, ref_m);
      bus(1, `DIO_OFS_BSTEP, 0);
      bus(1, `DIO_OFS_CTRL, 32'h01);
      pins(16'h0005);
      repeat (30) @(posedge clk);
      pins(16'h0004);
      bus(0, `DIO_OFS_BIAS, 0);
      b = $signed(r[15:0]);
      chk1(b > 30 && b < 60, 1'b1);
      chk16(fref, 16'(ref_m + b));
      pins(16'h0007);
      bus(0, `DIO_OFS_BIAS, 0);
      chk16(r[15:0], 16'(b));
      repeat (250) @(posedge clk);
      bus(0, `DIO_OFS_SAVED, 0);
      chk16(r[15:0], 16'(b));
      bus(0, `DIO_OFS_REF, 0);
      chk16(r[15:0], 16'(ref_m));
      pins(16'h0005);
      pins(16'h0004);
      bus(0, `DIO_OFS_BIAS, 0);
      b2 = $signed(r[15:0]);
      repeat (100) @(posedge clk);
      bus(0, `DIO_OFS_SAVED, 0);
      chk16(r[15:0], 16'(b));
      repeat (100) @(posedge clk);
      bus(0, `DIO_OFS_SAVED, 0);
      chk16(r[15:0], 16'(b2));
      $display("test continuous bias done");
      pins(16'h0004);
      bus(1, `DIO_OFS_CTRL, 32'h03);
      bus(1, `DIO_OFS_BSTEP, 32'h32);
      ref_m = ($urandom % 2048) + 1024;
      bus(1, `DIO_OFS_REF, ref_m);
      bus(0, `DIO_OFS_BIAS, 0);
      chk16(r[15:0], 16'h0000);
      pins(16'h0006);
      pins(16'h0004);
      bus(0, `DIO_OFS_BIAS, 0);
      chk16(r[15:0], 16'hFFCE);
      chk16(fref, 16'(ref_m - 50));
      repeat (260) @(posedge clk);
      bus(0, `DIO_OFS_BIAS, 0);
      chk16(r[15:0], 16'h0000);
      chk16(fref, 16'(ref_m - 50));
      ref_m = ref_m - 50;
      pins(16'h0005);
      pins(16'h0004);
      bus(0, `DIO_OFS_BIAS, 0);
      chk16(r[15:0], 16'h0032);
      chk16(fref, 16'(ref_m + 50));
      ref_m = ref_m + 100;
      bus(1, `DIO_OFS_REF, ref_m);
      bus(0, `DIO_OFS_BIAS, 0);
      chk16(r[15:0], 16'h0000);
      chk16(fref, 16'(ref_m));
      $display("test step bias done");
      bus(1, `DIO_OFS_CHGT, 32'h02);
      bus(1, `DIO_OFS_CTRL, 32'h21);
      bus(1, `DIO_OFS_REF, ref_m + 1);
      bus(1, `DIO_OFS_REF, ref_m + 2);
      bus(0, `DIO_OFS_STAT, 0);
      chk1(r[7], 1'b0);
      bus(1, `DIO_OFS_REF, ref_m + 3);
      ref_m = ref_m + 3;
      pins(16'h0005);
      pins(16'h0004);
      bus(0, `DIO_OFS_BIAS, 0);
      chk16(r[15:0], 16'h0000);
      bus(0, `DIO_OFS_STAT, 0);
      chk1(r[7], 1'b1);
      bus(1, `DIO_OFS_CTRL, 32'h41);
      bus(0, `DIO_OFS_STAT, 0);
      chk1(r[7], 1'b0);
      $display("test reference change hold done");
      bus(1, `DIO_OFS_CTRL, 32'h00);
      for (int i = 0; i < 6; i++)
      begin
         pins(16'h0004 ^ (16'h0001 << pt[i]));
         chk16({11'h0, o[4:0]}, {11'h0, ex[i]});
      end
      pins(16'h0004);
      bus(1, `DIO_OFS_CTRL, 32'h10);
      pins(16'h0224);
      chk16({14'h0, o[5], o[1]}, 16'h0002);
      pins(16'h0234);
      chk1(o[5], 1'b0);
      pins(16'h0004);
      chk1(o[5], 1'b0);
      bus(1, `DIO_OFS_CTRL, 32'h00);
      $display("test pin functions done");
      pins(16'h2004);
      chk1(o[13], 1'b0);
      pins(16'h3004);
      chk1(o[13], 1'b0);
      pins(16'h1004);
      pins(16'h3004);
      chk1(o[13], 1'b1);
      $display("test drive enable done");
      pins(16'h0004);
      bus(1, `DIO_OFS_OVSPD, 32'h0309);
      bus(1, `DIO_OFS_CTRL, 32'h04);
      pins(16'hD404);
      chk16(fref, 16'h0309);
      chk16({9'h0, o[14:13], o[11:10], o[8:6]}, 16'h0039);
      bus(1, `DIO_OFS_CTRL, 32'h0C);
      repeat (4) @(posedge clk);
      chk16(fref, 16'(ref_m));
      pins(16'hC804);
      chk1(o[7], 1'b1);
      b = 0;
      repeat (40)
      begin
         @(posedge clk);
         b = b + o[12];
      end
      chk16(16'(b), 16'h0014);
      pins(16'hCC04);
      chk1(o[8], 1'b1);
      pins(16'h0004);
      bus(1, `DIO_OFS_CTRL, 32'h00);
      pins(16'h0404);
      chk1(o[6], 1'b0);
      $display("test override done");
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      bus(0, `DIO_OFS_CTRL, 0);
      chk16(r[15:0], {8'h00, `DIO_CTRL_RST});
      bus(0, `DIO_OFS_SAVED, 0);
      chk16(r[15:0], 16'h0000);
      $display("test mid-run reset done");
      results;
   end
endmodule // drive_input_override_logic_tb_top
